// ---- hw/smct_pkg.sv ----
`default_nettype none
package smct_pkg;
  // Register write addresses; the read address is the write address plus one
  localparam logic [7:0] SERIAL_PIN_PULL_CFG_OFS       = 8'h6A;
  localparam logic [7:0] RECOVERY_DELAY_CFG_OFS        = 8'h6C;
  localparam logic [7:0] CONTACTOR_TIMER_CFG_OFS       = 8'h6E;
  localparam logic [7:0] MONITOR_SCAN_INTERVAL_CFG_OFS = 8'h70;
  localparam logic [7:0] MONITOR_OUTPUT_MASK_CFG_OFS   = 8'h72;
  localparam logic [7:0] READ_ADDR_BIT                 = 8'h01;

  // Reset values
  localparam logic [7:0] SERIAL_PIN_PULL_CFG_RST       = 8'h80;
  localparam logic [7:0] RECOVERY_DELAY_CFG_RST        = 8'h00;
  localparam logic [7:0] CONTACTOR_TIMER_CFG_RST       = 8'hFF;
  localparam logic [1:0] MONITOR_SCAN_INTERVAL_CFG_RST = 2'h0;
  localparam logic [3:0] OUTPUT_SAFETY_MASK_RST        = 4'hF;
  localparam logic       NO_MONITORING_RST             = 1'b0;

  // Field positions
  localparam int SELECT_PULLUP_EN_BIT    = 0;
  localparam int DATA_IN_PULLDOWN_EN_BIT = 1;
  localparam int NO_MONITORING_BIT       = 7;

  // Special codes
  localparam logic [7:0] RECOVERY_DISABLED_CODE = 8'hFF;
  localparam logic [7:0] CONTACTOR_INFINITE_CODE = 8'hFF;
  localparam logic [1:0] SCAN_RESERVED_CODE     = 2'h3;

  // Timing
  localparam int CLK_FREQ_HZ    = 10_000_000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES    = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int MS_PER_MIN     = 60_000;
  localparam int TIMER_W        = 12;
  localparam logic [TIMER_W-1:0] REC_BASE_MS   = 12'd100;
  localparam logic [TIMER_W-1:0] REC_STEP_MS   = 12'd10;
  localparam logic [TIMER_W-1:0] CONT_BASE_MIN = 12'd16;
  localparam logic [TIMER_W-1:0] CONT_MULT     = 12'd4;
  localparam logic [TIMER_W-1:0] SCAN_STEP_MS  = 12'd500;

  typedef enum logic [1:0] {
    REC_IDLE,
    REC_TIMING,
    REC_MONITOR,
    REC_FAILSAFE
  } smct_rec_state_t;
endpackage
`default_nettype wire

// ---- hw/smct_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module smct_timer #(
  parameter int W = 12
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         stop,
  input  wire logic [W-1:0] load_val,
  output logic              running_q,
  output logic              done_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         running_d;
  logic         done_d;

  // Down counter of ticks, reloaded when a phase begins
  always_comb begin
    cnt_d     = cnt_q;
    running_d = running_q;
    done_d    = 1'b0;
    if (load) begin
      cnt_d     = load_val;
      running_d = 1'b1;
    end else if (stop) begin
      running_d = 1'b0;
    end else if (running_q && tick) begin
      if (cnt_q <= W'(1)) begin
        running_d = 1'b0;
        done_d    = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q     <= '0;
      running_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      running_q <= running_d;
      done_q    <= done_d;
    end
  end
endmodule
`default_nettype wire

// ---- hw/smct_top.sv ----
// Function
// - Two bits enable data-in pulldown, select pullup
// - Recovery delay is 100 ms plus 10 ms/code
// - Code 0xFE gives 2640 ms; 0xFF disables
// - Contactor minutes equal four times code plus 16
// - Contactor code resets 0xFF, meaning never expires
// - Contactor expiry asserts safe-monitoring outputs 0, 1
// - Scan interval 500 ms, 1 s, 1.5 s
// - Mask bits suppress safe-monitoring outputs in safety states outside failsafe
// - Expiry starts monitoring, or asserts all safe-monitoring outputs
`timescale 1ns/1ps
`default_nettype none
module smct_top import smct_pkg::*; #(
  parameter int MS_CYCLES     = TICK_CYCLES,
  parameter int MS_PER_MINUTE = MS_PER_MIN
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  input  wire logic       recovery_start,
  input  wire logic       watchdog_refresh,
  input  wire logic       contactor_start,
  input  wire logic       contactor_stop,
  input  wire logic       scan_enable,
  input  wire logic       safety_measure_state,
  input  wire logic [3:0] output_safe_monitoring_sel,
  input  wire logic [3:0] output_drive_req,
  output logic      [3:0] output_pin_q,
  output logic            data_in_pulldown_en_q,
  output logic            select_pullup_en_q,
  output logic            recovery_expired_q,
  output logic            chain_monitor_start_q,
  output logic            all_outputs_assert_q,
  output logic            contactor_expired_q,
  output logic            scan_tick_q
);
  localparam int MS_W  = $clog2(MS_CYCLES + 1);
  localparam int MIN_W = $clog2(MS_PER_MINUTE + 1);

  // Configuration registers
  logic [7:0] pull_cfg_q, pull_cfg_d;
  logic [7:0] rec_cfg_q, rec_cfg_d;
  logic [7:0] cont_cfg_q, cont_cfg_d;
  logic [1:0] scan_cfg_q, scan_cfg_d;
  logic [3:0] mask_q, mask_d;
  logic       no_monitoring_q, no_monitoring_d;
  logic [7:0] rdata_d;

  always_comb begin
    pull_cfg_d      = pull_cfg_q;
    rec_cfg_d       = rec_cfg_q;
    cont_cfg_d      = cont_cfg_q;
    scan_cfg_d      = scan_cfg_q;
    mask_d          = mask_q;
    no_monitoring_d = no_monitoring_q;
    rdata_d         = reg_rdata_q;
    if (reg_wr_en) begin
      unique case (reg_addr)
        SERIAL_PIN_PULL_CFG_OFS: pull_cfg_d = reg_wdata;
        RECOVERY_DELAY_CFG_OFS: rec_cfg_d = reg_wdata;
        CONTACTOR_TIMER_CFG_OFS: cont_cfg_d = reg_wdata;
        MONITOR_SCAN_INTERVAL_CFG_OFS: scan_cfg_d = reg_wdata[1:0];
        MONITOR_OUTPUT_MASK_CFG_OFS: begin
          mask_d          = reg_wdata[3:0];
          no_monitoring_d = reg_wdata[NO_MONITORING_BIT];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        SERIAL_PIN_PULL_CFG_OFS | READ_ADDR_BIT: rdata_d = pull_cfg_q;
        RECOVERY_DELAY_CFG_OFS | READ_ADDR_BIT: rdata_d = rec_cfg_q;
        CONTACTOR_TIMER_CFG_OFS | READ_ADDR_BIT: rdata_d = cont_cfg_q;
        MONITOR_SCAN_INTERVAL_CFG_OFS | READ_ADDR_BIT:
          rdata_d = {6'h00, scan_cfg_q};
        MONITOR_OUTPUT_MASK_CFG_OFS | READ_ADDR_BIT:
          rdata_d = {no_monitoring_q, 3'h0, mask_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pull_cfg_q      <= SERIAL_PIN_PULL_CFG_RST;
      rec_cfg_q       <= RECOVERY_DELAY_CFG_RST;
      cont_cfg_q      <= CONTACTOR_TIMER_CFG_RST;
      scan_cfg_q      <= MONITOR_SCAN_INTERVAL_CFG_RST;
      mask_q          <= OUTPUT_SAFETY_MASK_RST;
      no_monitoring_q <= NO_MONITORING_RST;
      reg_rdata_q     <= 8'h00;
    end else begin
      pull_cfg_q      <= pull_cfg_d;
      rec_cfg_q       <= rec_cfg_d;
      cont_cfg_q      <= cont_cfg_d;
      scan_cfg_q      <= scan_cfg_d;
      mask_q          <= mask_d;
      no_monitoring_q <= no_monitoring_d;
      reg_rdata_q     <= rdata_d;
    end
  end

  // Millisecond and minute enables
  logic [MS_W-1:0]  ms_cnt_q, ms_cnt_d;
  logic [MIN_W-1:0] min_cnt_q, min_cnt_d;
  logic             ms_tick_q, ms_tick_d;
  logic             min_tick_q, min_tick_d;

  always_comb begin
    ms_cnt_d   = ms_cnt_q + MS_W'(1);
    ms_tick_d  = 1'b0;
    min_cnt_d  = min_cnt_q;
    min_tick_d = 1'b0;
    if (ms_cnt_q >= MS_W'(MS_CYCLES - 1)) begin
      ms_cnt_d  = '0;
      ms_tick_d = 1'b1;
    end
    if (contactor_start) begin
      min_cnt_d = '0;
    end else if (ms_tick_q) begin
      if (min_cnt_q >= MIN_W'(MS_PER_MINUTE - 1)) begin
        min_cnt_d  = '0;
        min_tick_d = 1'b1;
      end else begin
        min_cnt_d = min_cnt_q + MIN_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ms_cnt_q   <= '0;
      ms_tick_q  <= 1'b0;
      min_cnt_q  <= '0;
      min_tick_q <= 1'b0;
    end else begin
      ms_cnt_q   <= ms_cnt_d;
      ms_tick_q  <= ms_tick_d;
      min_cnt_q  <= min_cnt_d;
      min_tick_q <= min_tick_d;
    end
  end

  // Timer reload values
  logic [TIMER_W-1:0] rec_load_val;
  logic [TIMER_W-1:0] cont_load_val;
  logic [TIMER_W-1:0] scan_load_val;
  logic               rec_enabled;
  logic               cont_finite;

  assign rec_load_val  = REC_BASE_MS +
                         REC_STEP_MS * {4'h0, rec_cfg_q};
  assign rec_enabled   = (rec_cfg_q != RECOVERY_DISABLED_CODE);
  assign cont_load_val = CONT_BASE_MIN +
                         CONT_MULT * {4'h0, cont_cfg_q};
  assign cont_finite   = (cont_cfg_q != CONTACTOR_INFINITE_CODE);
  assign scan_load_val = (scan_cfg_q == SCAN_RESERVED_CODE) ? SCAN_STEP_MS :
                         SCAN_STEP_MS * {10'h000, scan_cfg_q + 2'h1};

  // Recovery phase state machine
  smct_rec_state_t rec_state_q, rec_state_d;
  logic            rec_load, rec_stop, rec_done;
  logic            rec_expired_d, chain_start_d;

  always_comb begin
    rec_state_d   = rec_state_q;
    rec_load      = 1'b0;
    rec_stop      = 1'b0;
    rec_expired_d = 1'b0;
    chain_start_d = 1'b0;
    if (recovery_start) begin
      rec_load    = rec_enabled;
      rec_stop    = ~rec_enabled;
      rec_state_d = rec_enabled ? REC_TIMING : REC_IDLE;
    end else begin
      unique case (rec_state_q)
        REC_IDLE: begin
        end
        REC_TIMING: begin
          if (watchdog_refresh) begin
            rec_stop    = 1'b1;
            rec_state_d = REC_IDLE;
          end else if (rec_done) begin
            rec_expired_d = 1'b1;
            chain_start_d = ~no_monitoring_q;
            rec_state_d   = no_monitoring_q ? REC_FAILSAFE : REC_MONITOR;
          end
        end
        REC_MONITOR, REC_FAILSAFE: begin
          if (watchdog_refresh) begin
            rec_state_d = REC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rec_state_q           <= REC_IDLE;
      recovery_expired_q    <= 1'b0;
      chain_monitor_start_q <= 1'b0;
      all_outputs_assert_q  <= 1'b0;
    end else begin
      rec_state_q           <= rec_state_d;
      recovery_expired_q    <= rec_expired_d;
      chain_monitor_start_q <= chain_start_d;
      all_outputs_assert_q  <= (rec_state_d == REC_FAILSAFE);
    end
  end

  smct_timer #(.W(TIMER_W)) u_rec_timer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .tick      (ms_tick_q),
    .load      (rec_load),
    .stop      (rec_stop),
    .load_val  (rec_load_val),
    .running_q (),
    .done_q    (rec_done)
  );

  // Contactor timer, scan timer and output drive
  logic       cont_done, cont_expired_d;
  logic       scan_done, scan_en_prev_q, scan_load;
  logic [3:0] pin_d;

  assign scan_load = scan_enable & (~scan_en_prev_q | scan_done);

  always_comb begin
    cont_expired_d = contactor_expired_q;
    if (contactor_stop || contactor_start) begin
      cont_expired_d = 1'b0;
    end
    if (cont_done) begin
      cont_expired_d = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      pin_d[i] = output_drive_req[i];
      if (output_safe_monitoring_sel[i]) begin
        pin_d[i] = output_drive_req[i] |
                   ((i < 2) & contactor_expired_q);
        if (mask_q[i] && safety_measure_state) begin
          pin_d[i] = 1'b0;
        end
        if (all_outputs_assert_q) begin
          pin_d[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      contactor_expired_q   <= 1'b0;
      scan_en_prev_q        <= 1'b0;
      scan_tick_q           <= 1'b0;
      output_pin_q          <= 4'h0;
      data_in_pulldown_en_q <= 1'b0;
      select_pullup_en_q    <= 1'b0;
    end else begin
      contactor_expired_q   <= cont_expired_d;
      scan_en_prev_q        <= scan_enable;
      scan_tick_q           <= scan_done & scan_enable;
      output_pin_q          <= pin_d;
      data_in_pulldown_en_q <= pull_cfg_q[DATA_IN_PULLDOWN_EN_BIT];
      select_pullup_en_q    <= pull_cfg_q[SELECT_PULLUP_EN_BIT];
    end
  end

  smct_timer #(.W(TIMER_W)) u_cont_timer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .tick      (min_tick_q),
    .load      (contactor_start & cont_finite),
    .stop      (contactor_stop | (contactor_start & ~cont_finite)),
    .load_val  (cont_load_val),
    .running_q (),
    .done_q    (cont_done)
  );

  smct_timer #(.W(TIMER_W)) u_scan_timer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .tick      (ms_tick_q),
    .load      (scan_load),
    .stop      (~scan_enable),
    .load_val  (scan_load_val),
    .running_q (),
    .done_q    (scan_done)
  );
endmodule
`default_nettype wire

// ---- test/smct_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module smct_chk (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       recovery_start,
  input wire logic       contactor_start,
  input wire logic       scan_enable,
  input wire logic       safety_measure_state,
  input wire logic [3:0] output_safe_monitoring_sel,
  input wire logic [3:0] output_drive_req,
  input wire logic [3:0] output_pin_q,
  input wire logic       data_in_pulldown_en_q,
  input wire logic       select_pullup_en_q,
  input wire logic       recovery_expired_q,
  input wire logic       chain_monitor_start_q,
  input wire logic       all_outputs_assert_q,
  input wire logic       contactor_expired_q,
  input wire logic       scan_tick_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property pull_p;
    logic [1:0] v;
    (reg_wr_en && reg_addr == 8'h6A, v = reg_wdata[1:0]) |->
      ##2 {data_in_pulldown_en_q, select_pullup_en_q} == v;
  endproperty
  pull_mirror_a: assert property (pull_p) else $error("pull bits");
  rec_min_a: assert property (
    recovery_start |=> !recovery_expired_q[*8]) else $error("early expiry");
  chain_start_a: assert property (
    chain_monitor_start_q |-> recovery_expired_q && !all_outputs_assert_q)
    else $error("chain start");
  fail_pins_a: assert property (
    all_outputs_assert_q |=> (output_pin_q & $past(output_safe_monitoring_sel))
    == $past(output_safe_monitoring_sel)) else $error("failsafe pins");
  plain_pins_a: assert property (
    1 |=> ((output_pin_q ^ $past(output_drive_req))
    & ~$past(output_safe_monitoring_sel)) == 4'h0) else $error("plain pins");
  cont_pins_a: assert property (
    contactor_expired_q && !safety_measure_state |=> (output_pin_q[1:0]
    & $past(output_safe_monitoring_sel[1:0])) == $past(output_safe_monitoring_sel[1:0]))
    else $error("contactor pins");
  cont_min_a: assert property (
    contactor_start |=> !contactor_expired_q[*8]) else $error("early timer");
  scan_stop_a: assert property (
    !scan_enable [*2] |-> !scan_tick_q) else $error("tick while off");
  cover property (chain_monitor_start_q);
  cover property ($rose(all_outputs_assert_q));
  cover property (contactor_expired_q);
  cover property (scan_tick_q);
endmodule
`default_nettype wire

// ---- test/smct_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module smct_host_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic       wr,
  input  wire logic [7:0] ad,
  input  wire logic [7:0] wd,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  logic       g_q = 1'b0;
  logic       w_q = 1'b0;
  logic [7:0] a_q = 8'h00;
  logic [7:0] d_q = 8'h00;
  // One-cycle access per go; idle lines invert each cycle, so stale data matches only on every other idle cycle
  always @(posedge clk_sys) begin
    g_q <= go;
    w_q <= wr;
    a_q <= go ? ad : ~a_q;
    d_q <= go ? wd : ~d_q;
  end
  assign reg_wr_en = g_q & w_q;
  assign reg_rd_en = g_q & ~w_q;
  assign reg_addr  = a_q;
  assign reg_wdata = d_q;
endmodule
`default_nettype wire

// ---- test/smct_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module smct_top_bench;
  localparam int MSC = 2;
  localparam int MPM = 2;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } smct_row_t;
  logic       clk_sys = 1'b0, reset = 1'b1, go = 1'b0, wr = 1'b0;
  logic [7:0] ad = 8'h00, wd = 8'h00, reg_addr, reg_wdata, reg_rdata_q;
  logic       recovery_start = 1'b0, watchdog_refresh = 1'b0;
  logic       contactor_start = 1'b0, contactor_stop = 1'b0;
  logic       scan_enable = 1'b0, safety_measure_state = 1'b0;
  logic [3:0] output_safe_monitoring_sel = 4'h0, output_drive_req = 4'h0, output_pin_q;
  logic       reg_wr_en, reg_rd_en, data_in_pulldown_en_q, select_pullup_en_q;
  logic       recovery_expired_q, chain_monitor_start_q, all_outputs_assert_q;
  logic       contactor_expired_q, scan_tick_q;
  wire  [2:0] flg = {scan_tick_q, contactor_expired_q, recovery_expired_q};
  int         fails = 0;
  int         tests_run = 0;
  int         n;
  int         per;
  logic [7:0] rstv [5] = '{8'h80, 8'h00, 8'hFF, 8'h00, 8'h0F};
  smct_row_t  rows [7] = '{'{8'h6A, 8'h03, 8'h03}, '{8'h6C, 8'h05, 8'h05},
    '{8'h6E, 8'h12, 8'h12}, '{8'h70, 8'h02, 8'h02}, '{8'h70, 8'hFF, 8'h03},
    '{8'h72, 8'h85, 8'h85}, '{8'h60, 8'h55, 8'h00}};

  smct_host_model u_smct_host_model (.*);
  smct_top #(.MS_CYCLES(MSC), .MS_PER_MINUTE(MPM)) u_smct_top (.*);

  always #50 clk_sys = ~clk_sys;

  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      fails++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, n);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic [1:0] i);
    {contactor_stop, contactor_start, watchdog_refresh,
     recovery_start} <= 4'h1 << i;
    @(posedge clk_sys);
    {contactor_stop, contactor_start, watchdog_refresh, recovery_start} <= 4'h0;
  endtask
  task automatic meas(input int s, input int lim, input logic hit);
    n = 0;
    while (flg[s] !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (hit && n >= lim) begin
      fails++;
      $display("unexpected flag %0d exp set got clear", s);
      give_verdict;
    end
  endtask
  task automatic rec(input logic [7:0] c, input int lim);
    acc(1'b1, 8'h6C, c);
    pulse(2'd0);
    meas(0, lim, c != 8'hFF);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    foreach (rstv[i]) begin
      acc(1'b0, 8'h6B + 8'(2 * i), 8'h00);
      chk("reset value", rstv[i], reg_rdata_q);
    end
    chk("pull pins", 8'h00,
        {6'h00, data_in_pulldown_en_q, select_pullup_en_q});
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].d);
      acc(1'b0, rows[i].a + 8'h01, 8'h00);
      chk("reg read", rows[i].e, reg_rdata_q);
    end
    chk("pulls", 8'h03,
        {6'h00, data_in_pulldown_en_q, select_pullup_en_q});
    acc(1'b1, 8'h6A, 8'h02);
    @(posedge clk_sys);
    chk("pulls", 8'h02,
        {6'h00, data_in_pulldown_en_q, select_pullup_en_q});
    acc(1'b1, 8'h72, 8'h0F);
    output_safe_monitoring_sel <= 4'hF;
    rec(8'h00, 400);
    rng("rec 00", 99 * MSC - 1, 100 * MSC + 4);
    chk("chain start", 8'h01, {7'h00, chain_monitor_start_q});
    rec(8'h01, 400);
    rng("rec 01", 109 * MSC - 1, 110 * MSC + 4);
    rec(8'hFE, 6000);
    rng("rec FE", 2639 * MSC - 1, 2640 * MSC + 4);
    rec(8'hFF, 600);
    rng("rec FF", 600, 600);
    acc(1'b1, 8'h72, 8'h80);
    rec(8'h00, 400);
    chk("failsafe", 8'h01, {7'h00, all_outputs_assert_q});
    @(posedge clk_sys);
    chk("fail pins", 8'h0F, {4'h0, output_pin_q});
    pulse(2'd1);
    repeat (2) @(posedge clk_sys);
    chk("refresh", 8'h00, {7'h00, all_outputs_assert_q});
    acc(1'b1, 8'h72, 8'h05);
    output_safe_monitoring_sel <= 4'h7;
    output_drive_req <= 4'hF;
    safety_measure_state <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("mask pins", 8'h0A, {4'h0, output_pin_q});
    safety_measure_state <= 1'b0;
    output_drive_req <= 4'h0;
    output_safe_monitoring_sel <= 4'hF;
    acc(1'b1, 8'h6E, 8'hFF);
    pulse(2'd2);
    meas(1, 200, 1'b0);
    rng("cont FF", 200, 200);
    for (int c = 0; c < 2; c++) begin
      acc(1'b1, 8'h6E, c[7:0]);
      pulse(2'd2);
      meas(1, 400, 1'b1);
      per = (4 * c + 16) * MPM * MSC;
      rng("cont delay", per - 3, per + 4);
      @(posedge clk_sys);
      chk("cont pins", 8'h03, {4'h0, output_pin_q});
      pulse(2'd3);
    end
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 8'h70, c[7:0]);
      scan_enable <= 1'b1;
      meas(2, 7000, 1'b1);
      @(posedge clk_sys);
      meas(2, 7000, 1'b1);
      per = (c == 3 ? 1 : c + 1) * 500 * MSC;
      rng("scan gap", per - 2, per);
      scan_enable <= 1'b0;
      @(posedge clk_sys);
    end
    output_drive_req <= 4'hF;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("reset outs", 8'h00, {output_pin_q, 2'b00, data_in_pulldown_en_q,
        select_pullup_en_q});
    output_drive_req <= 4'h0;
    @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    acc(1'b0, 8'h6F, 8'h00);
    chk("reset cont", 8'hFF, reg_rdata_q);
    give_verdict;
  end
endmodule

bind smct_top smct_chk u_smct_chk (.*);
`default_nettype wire
